/* logic/slave_watchdog_pkg.sv */
// Constants for the slave watchdog and state control block.
// Assumes a single 50 MHz clock; the 25 MHz local tick is an enable pulse.
package slave_watchdog_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 50000000;
  localparam int LOCAL_HZ = 25000000;
  // System clocks per 40 ns local period
  localparam int LOCAL_DIV = CLK_HZ / LOCAL_HZ;
  localparam int LOCAL_PERIOD_NS = 40;
  localparam int TICK_EXTRA = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] MULT_RESET = 16'h09C2;
  localparam logic [15:0] SM_TIME_RESET = 16'h03E8;
  localparam logic [15:0] LPI_TIME_RESET = 16'h03E8;

  // ****************************************
  // State request codes
  // ****************************************
  localparam logic [2:0] REQ_STARTUP = 3'h1;
  localparam logic [2:0] REQ_CONFIGURING = 3'h2;
  localparam logic [2:0] REQ_FW_UPDATE = 3'h3;
  localparam logic [2:0] REQ_SAFE_RUNNING = 3'h4;
  localparam logic [2:0] REQ_RUNNING = 3'h5;

  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_CONFIGURING,
    ST_SAFE_RUNNING,
    ST_RUNNING,
    ST_FW_UPDATE
  } slave_state_t;

  typedef enum logic [1:0] {
    AK_IDLE,
    AK_COPY
  } ack_state_t;

endpackage

/* logic/watchdog_timer.sv */
// One watchdog channel: counts shared ticks, trips on silence.
// Assumes tick is a one-cycle enable from the shared divider.
`timescale 1ns/1ps
module watchdog_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [WIDTH-1:0] limit,
  input wire logic tick,
  input wire logic kick,
  output logic tripped
);

  logic [WIDTH-1:0] count;

  // Zero limit switches the channel off entirely
  wire logic armed = enable && (limit != '0);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= '0;
    end else if (kick || !armed) begin
      count <= '0;
    end else if (tick && !tripped && count != limit) begin
      count <= count + 1'b1;
    end
  end

  // Sticky until valid traffic restarts the channel
  // A trip in the same cycle as a kick wins; the next kick clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tripped <= 1'b0;
    end else if (armed && tick && !tripped && count == limit) begin
      tripped <= 1'b1;
    end else if (kick || !armed) begin
      tripped <= 1'b0;
    end
  end

endmodule

/* logic/slave_watchdog_state_control.sv */
// Watchdogs and slave state machine of a fieldbus slave controller.
// Assumes all inputs are synchronous to clk; requests are one-cycle pulses.
`timescale 1ns/1ps

// Summary of operation
// R01: Two independent watchdogs, default 100 ms.
// R02: Process exchange restarts and clears bus watchdog.
// R03: Bus watchdog silence trips, outputs forced false.
// R04: Bus watchdog trip leaves running state; the code keeps the state and only forces outputs to zero.
// R05: Local interface watchdog trips without local access.
// R06: Shared multiplier, separate timer values.
// R07: Master loads settings only at startup.
// R08: Tick is multiplier plus two 40 ns periods.
// R09: Multiplier resets to 2498, 100 us tick.
// R10: Bus watchdog timer defaults to 1000.
// R11: Timers 0..65535, multiplier 1..65535.
// R12: Zero bus timer disables the watchdog.
// R13: Five states, running is normal.
// R14: Startup after reset, no traffic.
// R15: Master sets mailbox channels in startup.
// R16: Check mailbox setup before configuring.
// R17: Configuring allows mailbox, no process data.
// R18: Master sets process channels in configuring.
// R19: Check process and clock setup.
// R20: Copy inputs before acking safe running.
// R21: Safe running: traffic on, outputs safe.
// R22: Master drives every state change.
// R23: Running copies master outputs to outputs.
// R24: Firmware update only from startup, file only.
// R25: Illegal request refused, error flag raised.
// R26: Trip flags sticky until traffic restarts.
module slave_watchdog_state_control #(
  parameter int OUT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic settings_load,
  input wire logic manual_enable,
  input wire logic [15:0] mult_in,
  input wire logic [15:0] sm_time_in,
  input wire logic [15:0] lpi_time_in,
  input wire logic sm_wd_enable,
  input wire logic lpi_wd_enable,
  input wire logic pd_exchange_ok,
  input wire logic lpi_access,
  input wire logic state_req_valid,
  input wire logic [2:0] state_req,
  input wire logic mailbox_setup_ok,
  input wire logic pd_setup_ok,
  input wire logic dc_used,
  input wire logic dc_setup_ok,
  input wire logic input_copy_done,
  input wire logic [OUT_WIDTH-1:0] master_out_data,
  output logic [2:0] current_state,
  output logic state_error,
  output logic input_copy_req,
  output logic mailbox_allowed,
  output logic file_mailbox_only,
  output logic pd_allowed,
  output logic [OUT_WIDTH-1:0] outputs,
  output logic sm_wd_tripped,
  output logic lpi_wd_tripped,
  output logic wd_tick
);

  // ****************************************
  // Watchdog settings
  // ****************************************
  logic [15:0] mult;
  logic [15:0] sm_time;
  logic [15:0] lpi_time;
  slave_watchdog_pkg::slave_state_t state;
  slave_watchdog_pkg::ack_state_t ack;

  // Loaded only in startup with manual setting on; else kept
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mult <= slave_watchdog_pkg::MULT_RESET; // R09
      sm_time <= slave_watchdog_pkg::SM_TIME_RESET; // R10
      lpi_time <= slave_watchdog_pkg::LPI_TIME_RESET; // R01
    end else if (settings_load && manual_enable &&
                 state == slave_watchdog_pkg::ST_STARTUP) begin // R07
      // Zero multiplier is out of range and ignored
      if (mult_in != 16'h0000) begin
        mult <= mult_in; // R11
      end
      sm_time <= sm_time_in; // R11
      lpi_time <= lpi_time_in;
    end
  end

  // ****************************************
  // Shared tick divider
  // ****************************************
  logic local_en;
  logic [$clog2(slave_watchdog_pkg::LOCAL_DIV+1)-1:0] div_count;
  logic [16:0] tick_count;

  // 25 MHz local enable from the 50 MHz clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_count <= '0;
    end else if (local_en) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end
  assign local_en = (32'(div_count) == slave_watchdog_pkg::LOCAL_DIV - 1);

  // Tick every mult+2 local periods
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_count <= '0;
      wd_tick <= 1'b0;
    end else begin
      wd_tick <= 1'b0;
      if (local_en) begin
        if (tick_count >= 17'(mult) + 17'(slave_watchdog_pkg::TICK_EXTRA) - 17'h00001) begin // R08
          tick_count <= '0;
          wd_tick <= 1'b1; // R06
        end else begin
          tick_count <= tick_count + 17'h00001;
        end
      end
    end
  end

  // ****************************************
  // Watchdog channels
  // ****************************************
  watchdog_timer #(.WIDTH(16)) sm_wd (
    .clk(clk),
    .nrst(nrst),
    .enable(sm_wd_enable),
    .limit(sm_time), // R12
    .tick(wd_tick), // R06
    .kick(pd_exchange_ok), // R02
    .tripped(sm_wd_tripped) // R26
  );

  watchdog_timer #(.WIDTH(16)) lpi_wd (
    .clk(clk),
    .nrst(nrst),
    .enable(lpi_wd_enable),
    .limit(lpi_time),
    .tick(wd_tick),
    .kick(lpi_access),
    .tripped(lpi_wd_tripped) // R05
  );

  // ****************************************
  // Slave state machine
  // ****************************************
  slave_watchdog_pkg::slave_state_t next_state;
  logic next_error;
  logic start_copy;

  // Watchdog trips never enter here: state is unaffected
  always_comb begin // R04
    next_state = state;
    next_error = 1'b0;
    start_copy = 1'b0;
    if (state_req_valid && ack == slave_watchdog_pkg::AK_IDLE) begin // R22
      case (state_req)
        slave_watchdog_pkg::REQ_STARTUP: begin
          next_state = slave_watchdog_pkg::ST_STARTUP;
        end
        slave_watchdog_pkg::REQ_CONFIGURING: begin
          if (state == slave_watchdog_pkg::ST_STARTUP && mailbox_setup_ok) begin // R16
            next_state = slave_watchdog_pkg::ST_CONFIGURING;
          end else if (state == slave_watchdog_pkg::ST_SAFE_RUNNING ||
                       state == slave_watchdog_pkg::ST_RUNNING ||
                       state == slave_watchdog_pkg::ST_CONFIGURING) begin
            next_state = slave_watchdog_pkg::ST_CONFIGURING;
          end else begin
            next_error = 1'b1; // R25
          end
        end
        slave_watchdog_pkg::REQ_FW_UPDATE: begin
          if (state == slave_watchdog_pkg::ST_STARTUP) begin // R24
            next_state = slave_watchdog_pkg::ST_FW_UPDATE;
          end else begin
            next_error = 1'b1; // R25
          end
        end
        slave_watchdog_pkg::REQ_SAFE_RUNNING: begin
          if (state == slave_watchdog_pkg::ST_CONFIGURING && pd_setup_ok &&
              (!dc_used || dc_setup_ok)) begin // R19
            start_copy = 1'b1; // R20
          end else if (state == slave_watchdog_pkg::ST_RUNNING ||
                       state == slave_watchdog_pkg::ST_SAFE_RUNNING) begin
            next_state = slave_watchdog_pkg::ST_SAFE_RUNNING;
          end else begin
            next_error = 1'b1; // R25
          end
        end
        slave_watchdog_pkg::REQ_RUNNING: begin
          if (state == slave_watchdog_pkg::ST_SAFE_RUNNING ||
              state == slave_watchdog_pkg::ST_RUNNING) begin
            next_state = slave_watchdog_pkg::ST_RUNNING; // R13
          end else begin
            next_error = 1'b1; // R25
          end
        end
        default: begin
          next_error = 1'b1; // R25
        end
      endcase
    end else if (ack == slave_watchdog_pkg::AK_COPY && input_copy_done) begin
      next_state = slave_watchdog_pkg::ST_SAFE_RUNNING; // R20
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= slave_watchdog_pkg::ST_STARTUP; // R14
    end else begin
      state <= next_state;
    end
  end

  // Safe running from configuring is acknowledged only after the input copy completes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack <= slave_watchdog_pkg::AK_IDLE;
    end else begin
      case (ack)
        slave_watchdog_pkg::AK_IDLE: begin
          if (start_copy) begin
            ack <= slave_watchdog_pkg::AK_COPY;
          end
        end
        slave_watchdog_pkg::AK_COPY: begin
          if (input_copy_done) begin
            ack <= slave_watchdog_pkg::AK_IDLE;
          end
        end
        default: begin
          ack <= slave_watchdog_pkg::AK_IDLE;
        end
      endcase
    end
  end
  assign input_copy_req = (ack == slave_watchdog_pkg::AK_COPY); // R20

  // Sticky error; a later accepted request clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_error <= 1'b0;
    end else if (next_error) begin
      state_error <= 1'b1; // R25
    end else if (state_req_valid && ack == slave_watchdog_pkg::AK_IDLE) begin
      state_error <= 1'b0;
    end
  end

  // ****************************************
  // Traffic gating and outputs
  // ****************************************
  assign current_state = state;

  always_comb begin
    mailbox_allowed = 1'b0;
    file_mailbox_only = 1'b0;
    pd_allowed = 1'b0;
    case (state)
      slave_watchdog_pkg::ST_STARTUP: begin
        mailbox_allowed = 1'b0; // R14
      end
      slave_watchdog_pkg::ST_CONFIGURING: begin
        mailbox_allowed = 1'b1; // R17
      end
      slave_watchdog_pkg::ST_SAFE_RUNNING,
      slave_watchdog_pkg::ST_RUNNING: begin
        mailbox_allowed = 1'b1; // R21
        pd_allowed = 1'b1;
      end
      slave_watchdog_pkg::ST_FW_UPDATE: begin
        mailbox_allowed = 1'b1; // R24
        file_mailbox_only = 1'b1;
      end
      default: begin
        mailbox_allowed = 1'b0;
      end
    endcase
  end

  // Outputs follow master only in running and with no bus trip
  always_ff @(posedge clk) begin
    if (!nrst) begin
      outputs <= '0;
    end else if (state == slave_watchdog_pkg::ST_RUNNING && !sm_wd_tripped) begin
      outputs <= master_out_data; // R23
    end else begin
      outputs <= '0; // R03 R21
    end
  end

endmodule

/* bench/slave_watchdog_state_control_props.sv */
// Port-level checker for the watchdog and state control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module slave_watchdog_state_control_props #(
  parameter int OUT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic state_req_valid,
  input wire logic [2:0] state_req,
  input wire logic input_copy_done,
  input wire logic pd_exchange_ok,
  input wire logic [OUT_WIDTH-1:0] master_out_data,
  input wire logic [2:0] current_state,
  input wire logic state_error,
  input wire logic input_copy_req,
  input wire logic mailbox_allowed,
  input wire logic file_mailbox_only,
  input wire logic pd_allowed,
  input wire logic [OUT_WIDTH-1:0] outputs,
  input wire logic sm_wd_tripped,
  input wire logic wd_tick
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_copy_done;
    current_state == 3'h1 && input_copy_req && input_copy_done;
  endsequence
  sequence s_bad_run;
    state_req_valid && state_req == 3'h5 && current_state == 3'h0 && !input_copy_req;
  endsequence
  sequence s_trip_held;
    sm_wd_tripped ##1 sm_wd_tripped;
  endsequence
  a_startup_no_traffic: assert property (
    current_state == 3'h0 |-> !mailbox_allowed && !pd_allowed) else $error("startup traffic");
  a_config_mailbox_only: assert property (
    current_state == 3'h1 |-> mailbox_allowed && !pd_allowed) else $error("configuring gates");
  a_fw_file_only: assert property (
    current_state == 3'h4 |-> file_mailbox_only && !pd_allowed) else $error("update gates");
  a_bad_run_refused: assert property (
    s_bad_run |=> state_error && current_state == 3'h0) else $error("illegal request taken");
  a_copy_to_safe: assert property (
    s_copy_done |=> current_state == 3'h2 && !input_copy_req) else $error("copy not acked");
  a_copy_holds_state: assert property (
    input_copy_req |-> current_state == 3'h1) else $error("state moved during copy");
  a_trip_zero_outputs: assert property (
    s_trip_held |-> outputs == '0) else $error("outputs live after trip");
  a_trip_keeps_state: assert property (
    $rose(sm_wd_tripped) && !$past(state_req_valid) && !$past(input_copy_done)
      |-> $stable(current_state)) else $error("trip changed state");
  a_kick_clears_trip: assert property (
    pd_exchange_ok && (sm_wd_tripped || !wd_tick) |=> !sm_wd_tripped)
    else $error("exchange left trip set");
  a_tick_one_cycle: assert property (
    wd_tick |=> !wd_tick [*5]) else $error("tick too dense");
  a_run_copies_data: assert property (
    (current_state == 3'h3 && !sm_wd_tripped) [*3] |-> outputs == $past(master_out_data))
    else $error("outputs not copied");
  a_nonrun_outputs_safe: assert property (
    current_state != 3'h3 ##1 current_state != 3'h3 |-> outputs == '0)
    else $error("outputs live outside running");
endmodule

bind slave_watchdog_state_control slave_watchdog_state_control_props #(
  .OUT_WIDTH(OUT_WIDTH)
) i_props (.clk, .nrst, .state_req_valid, .state_req, .input_copy_done, .pd_exchange_ok,
  .master_out_data, .current_state, .state_error, .input_copy_req, .mailbox_allowed,
  .file_mailbox_only, .pd_allowed, .outputs, .sm_wd_tripped, .wd_tick);

/* bench/fieldbus_master_model.sv */
// Behavioural bus master: state commands and process-data exchanges.
// Assumes go is raised for one cycle by the bench on a rising edge.
`timescale 1ns/1ps
module fieldbus_master_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] code,
  input wire logic pd_run,
  input wire logic slow,
  output logic state_req_valid,
  output logic [2:0] state_req,
  output logic pd_exchange_ok
);
  logic [3:0] gap;
  initial begin
    state_req_valid = 1'b0;
    state_req = 3'h0;
    pd_exchange_ok = 1'b0;
    gap = 4'h0;
  end
  // Idle code lines toggle so a stale code never looks meaningful
  always @(negedge clk) begin
    state_req_valid <= go;
    state_req <= go ? code : ~state_req;
    gap <= gap + 4'h1;
    pd_exchange_ok <= pd_run && (slow ? gap == 4'hF : gap[1:0] == 2'h3);
  end
endmodule

/* bench/slave_watchdog_state_control_tb_top.sv */
// Self-checking bench for the watchdog and state control block.
// Assumes the master model issues requests; timers shortened at startup.
`timescale 1ns/1ps
module slave_watchdog_state_control_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic settings_load = 1'b0, manual_enable = 1'b0, sm_wd_enable = 1'b0;
  logic lpi_wd_enable = 1'b0, lpi_access = 1'b0, mailbox_setup_ok = 1'b0;
  logic pd_setup_ok = 1'b0, dc_used = 1'b0, dc_setup_ok = 1'b0, input_copy_done = 1'b0;
  logic go = 1'b0, pd_run = 1'b0, slow = 1'b0;
  logic [15:0] mult_in = 16'h0001, sm_time_in = 16'h0003, lpi_time_in = 16'h0003;
  logic [2:0] code = 3'h0;
  logic [7:0] master_out_data = 8'hA5;
  logic state_req_valid, state_error, input_copy_req, mailbox_allowed, file_mailbox_only;
  logic pd_allowed, sm_wd_tripped, lpi_wd_tripped, wd_tick, pd_exchange_ok;
  logic [2:0] state_req, current_state;
  logic [7:0] outputs;
  int err_count = 0;
  int n_tests = 0;

  initial begin
    forever #10 clk = ~clk;
  end

  fieldbus_master_model i_master (.clk, .go, .code, .pd_run, .slow, .state_req_valid,
    .state_req, .pd_exchange_ok);
  slave_watchdog_state_control #(.OUT_WIDTH(8)) i_dut (.clk, .nrst, .settings_load,
    .manual_enable, .mult_in, .sm_time_in, .lpi_time_in, .sm_wd_enable, .lpi_wd_enable,
    .pd_exchange_ok, .lpi_access, .state_req_valid, .state_req, .mailbox_setup_ok,
    .pd_setup_ok, .dc_used, .dc_setup_ok, .input_copy_done, .master_out_data, .current_state,
    .state_error, .input_copy_req, .mailbox_allowed, .file_mailbox_only, .pd_allowed,
    .outputs, .sm_wd_tripped, .lpi_wd_tripped, .wd_tick);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic wait_flag(input int sel, input logic val);
    logic s;
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      s = sel == 0 ? input_copy_req : sel == 1 ? sm_wd_tripped : lpi_wd_tripped;
      if (s === val) return;
    end
    err_count++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask

  task automatic req(input logic [2:0] c);
    @(posedge clk);
    go <= 1'b1;
    code <= c;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_tick(input logic [15:0] exp);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (wd_tick !== 1'b1 && n < 20000);
      if (wd_tick !== 1'b1) begin
        err_count++;
        $display("[FAIL] %0t tick wait ran out", $time);
        give_verdict();
      end
    end
    chk(16'(n), exp, "tick period");
  endtask

  task automatic t_load;
    chk(16'(current_state), 16'h0000, "reset state");
    t_tick(16'h1388);
    manual_enable = 1'b1;
    settings_load = 1'b1;
    @(negedge clk);
    settings_load = 1'b0;
    t_tick(16'h0006);
  endtask

  task automatic t_walk;
    req(3'h2);
    chk(16'({current_state, state_error}), 16'h0001, "bad mailbox taken");
    mailbox_setup_ok = 1'b1;
    req(3'h2);
    chk(16'({current_state, mailbox_allowed, pd_allowed}), 16'h0006, "configuring");
    req(3'h4);
    chk(16'({current_state, state_error}), 16'h0003, "bad channels taken");
    pd_setup_ok = 1'b1;
    dc_used = 1'b1;
    req(3'h4);
    chk(16'({current_state, state_error}), 16'h0003, "bad clock taken");
    dc_setup_ok = 1'b1;
    req(3'h4);
    chk(16'({current_state, input_copy_req}), 16'h0003, "copy request");
    input_copy_done = 1'b1;
    wait_flag(0, 1'b0);
    input_copy_done = 1'b0;
    chk(16'({current_state, pd_allowed, outputs}), 16'h0500, "safe running");
    req(3'h5);
    @(negedge clk);
    chk(16'({current_state, outputs}), 16'h03A5, "running");
  endtask

  task automatic t_wd;
    sm_wd_enable = 1'b1;
    @(posedge clk);
    pd_run <= 1'b1;
    slow <= 1'b1;
    repeat (100) @(negedge clk);
    chk(16'(sm_wd_tripped), 16'h0000, "tripped with traffic");
    @(posedge clk);
    pd_run <= 1'b0;
    wait_flag(1, 1'b1);
    repeat (2) @(negedge clk);
    chk(16'({current_state, outputs}), 16'h0300, "trip result");
    @(posedge clk);
    pd_run <= 1'b1;
    wait_flag(1, 1'b0);
    repeat (3) @(negedge clk);
    chk(16'(outputs), 16'h00A5, "outputs back");
  endtask

  task automatic t_lpi;
    lpi_wd_enable = 1'b1;
    wait_flag(2, 1'b1);
    lpi_access = 1'b1;
    @(negedge clk);
    lpi_access = 1'b0;
    wait_flag(2, 1'b0);
  endtask

  task automatic t_illegal;
    mult_in = 16'h0004;
    settings_load = 1'b1;
    @(negedge clk);
    settings_load = 1'b0;
    t_tick(16'h0006);
    req(3'h3);
    chk(16'({current_state, state_error}), 16'h0007, "update from running");
    req(3'h1);
    sm_time_in = 16'h0000;
    settings_load = 1'b1;
    @(negedge clk);
    settings_load = 1'b0;
    @(posedge clk);
    pd_run <= 1'b0;
    repeat (60) @(negedge clk);
    chk(16'(sm_wd_tripped), 16'h0000, "zero timer tripped");
    req(3'h5);
    chk(16'({current_state, state_error}), 16'h0001, "running from startup");
    req(3'h3);
    chk(16'({current_state, file_mailbox_only, pd_allowed}), 16'h0012, "update");
  endtask

  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    t_load();
    t_walk();
    t_wd();
    t_lpi();
    t_illegal();
    give_verdict();
  end
endmodule
